// ---- include/spcb_pkg.sv ----
// Constants, types and helpers of the frame builder
package spcb_pkg;
    // Setup word field positions
    localparam int CFG_W = 16;
    localparam int CFG_ALT_ERR = 0;
    localparam int CFG_BLK_LO = 1;
    localparam int CFG_BLK_HI = 3;
    localparam int CFG_SLOW_OFF = 4;
    localparam int CFG_FC_ERR_OFF = 5;
    localparam int CFG_STAT_REV4 = 6;
    localparam int CFG_VN_EN = 7;
    localparam int CFG_CRC_STAT = 11;
    localparam int CFG_CRC_LEGACY = 12;
    localparam int CFG_VN_ID = 13;
    localparam int CFG_VN_RC = 14;
    localparam int CFG_RC4_TX = 15;

    // Fast channel error codes
    localparam logic [11:0] FC_SENSOR_ERR = 12'hFFB;
    localparam logic [11:0] FC_FUNC_ERR = 12'hFFA;

    // Error classes and fixed error-code bits
    localparam logic [11:0] ERR_SENSOR_MASK = 12'h4C8;
    localparam logic [11:0] ERR_FUNC_MASK = 12'h217;
    localparam logic [11:0] ERR_RSVD_MASK = 12'h100;
    localparam logic [11:0] ERR_ONE_MASK = 12'h800;

    // Checksums
    localparam logic [3:0] CRC4_SEED = 4'h5;
    localparam logic [3:0] CRC4_POLY = 4'hD;
    localparam logic [5:0] CRC6_SEED = 6'h15;
    localparam logic [5:0] CRC6_POLY = 6'h19;
    localparam int CRC6_AUG = 6;

    // Rolling counters
    localparam logic [3:0] RC4_RESET = 4'h0;
    localparam logic [3:0] RC4_MAX = 4'hF;
    localparam logic [3:0] RC4_WRAP = 4'h1;
    localparam logic [1:0] RC2_RESET = 2'h0;
    localparam logic [1:0] RC2_MAX = 2'h3;

    // Enhanced serial message framing
    localparam logic [4:0] SER_LAST = 5'h11;
    localparam logic [5:0] SER_SYNC = 6'h3F;
    localparam logic SER_CFG_BIT = 1'b0;
    localparam int SER_LEN = 18;

    // Message sequence
    localparam int NUM_BLK = 5;
    localparam logic [2:0] LAST_BLK = 3'h4;
    localparam logic [2:0] BLK_SERIAL = 3'h1;
    localparam logic [2:0] IDX_LAST = 3'h4;
    localparam logic [2:0] IDX_FIRST_ITEM = 3'h1;
    localparam logic [7:0] ERR_MSG_ID = 8'h01;
    localparam logic [11:0] PROTO_REV = 12'h004;
    localparam logic [11:0] MANUF_CODE_DFLT = 12'h0A5;
    localparam logic [7:0] MSG_ID [NUM_BLK][4] = '{
        '{8'h03, 8'h05, 8'h06, 8'h23},
        '{8'h29, 8'h2A, 8'h2B, 8'h2C},
        '{8'h07, 8'h08, 8'h09, 8'h0A},
        '{8'h90, 8'h91, 8'h92, 8'h93},
        '{8'h94, 8'h95, 8'h96, 8'h97}
    };
    localparam int CUST_BASE [NUM_BLK] = '{0, 0, 1, 4, 7};

    typedef logic [CFG_W-1:0] spcb_cfg_t;
    typedef logic [9:0][15:0] spcb_cust_t;

    typedef struct packed {
        logic [11:0] ch1;
        logic [11:0] ch2;
        logic [11:0] clamp_lo;
        logic [11:0] clamp_hi;
    } spcb_fast_t;

    typedef struct packed {
        logic [3:0] status;
        logic [5:0][3:0] data;
        logic [3:0] crc;
    } spcb_frame_t;

    typedef struct packed {
        logic [7:0] id;
        logic [11:0] data;
    } spcb_msg_t;

    typedef enum logic [1:0] {
        SC_OFF = 2'b00,
        SC_LOAD = 2'b01,
        SC_SEND = 2'b11
    } spcb_sc_state_t;

    // Augmented CRC6 over bit3/bit2 pairs of message frames 7 to 18
    function automatic logic [5:0] crc6_msg(input logic [11:0] b3, input logic [11:0] b2);
        logic [5:0] c;
        logic fb;
        c = CRC6_SEED;
        for (int i = 11; i >= 0; i--) begin
            fb = c[5];
            c = {c[4:0], b3[i]} ^ (fb ? CRC6_POLY : 6'h00);
            fb = c[5];
            c = {c[4:0], b2[i]} ^ (fb ? CRC6_POLY : 6'h00);
        end
        for (int i = 0; i < CRC6_AUG; i++) begin
            fb = c[5];
            c = {c[4:0], 1'b0} ^ (fb ? CRC6_POLY : 6'h00);
        end
        return c;
    endfunction
endpackage

// ---- testbench/spcb_ecu_model.sv ----
// Receiver model: rebuilds slow-channel messages
`timescale 1ns/10ps
`default_nettype none
module spcb_ecu_model (
    // Clock and frames
    input wire logic clk,
    input wire logic frame_valid,
    input wire spcb_pkg::spcb_frame_t frame,
    // Rebuilt message
    output logic msg_valid,
    output logic [7:0] msg_id,
    output logic [11:0] msg_data
);
    logic [17:0] hi_ff = '0;
    logic [17:0] lo_ff = '0;
    // Slow bits arrive reversed
    wire logic [17:0] nxt_hi = {hi_ff[16:0], frame.status[2]};
    wire logic [17:0] nxt_lo = {lo_ff[16:0], frame.status[3]};
    always_ff @(posedge clk) begin
        msg_valid <= 1'b0;
        if (frame_valid === 1'b1) begin
            hi_ff <= nxt_hi;
            lo_ff <= nxt_lo;
            if (nxt_hi[17:10] == 8'hFC && !nxt_hi[5] && !nxt_hi[0]) begin
                msg_valid <= 1'b1;
                msg_id <= {nxt_hi[9:6], nxt_hi[4:1]};
                msg_data <= nxt_lo[11:0];
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/spcb_frame_builder_asserts.sv ----
// Port checker of the frame builder
`timescale 1ns/10ps
`default_nettype none
module spcb_frame_builder_asserts (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Inputs
    input wire spcb_pkg::spcb_cfg_t SETUP_CFG,
    input wire spcb_pkg::spcb_fast_t FAST_IN,
    input wire logic [11:0] ERROR_FLAGS,
    input wire logic FRAME_REQ,
    // Outputs
    input wire logic FRAME_VALID,
    input wire spcb_pkg::spcb_frame_t FRAME,
    input wire logic [3:0] ROLL_COUNT,
    input wire logic SLOW_ACTIVE,
    input wire logic MSG_DONE
);
    import spcb_pkg::*;
    wire logic sens = |(ERROR_FLAGS & ERR_SENSOR_MASK);
    wire logic func = |(ERROR_FLAGS & ERR_FUNC_MASK);
    wire logic [11:0] ch1 = {FRAME.data[0], FRAME.data[1], FRAME.data[2]};
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    AST_FRAME_STEP: assert property (FRAME_REQ |=> FRAME_VALID && ROLL_COUNT != $past(ROLL_COUNT))
        else $error("Missing frame step");
    AST_IDLE_HOLD: assert property (!FRAME_REQ |=> !FRAME_VALID && $stable(ROLL_COUNT))
        else $error("Step without request");
    AST_RC4_WRAP: assert property (FRAME_REQ && ROLL_COUNT == 4'hF |=> ROLL_COUNT == 4'h1)
        else $error("Counter wrap wrong");
    AST_RC4_INC: assert property (FRAME_REQ && ROLL_COUNT != 4'hF |=> ROLL_COUNT == $past(ROLL_COUNT) + 4'h1)
        else $error("Counter step wrong");
    AST_STAT_ZERO: assert property (FRAME_REQ && !SETUP_CFG[CFG_STAT_REV4] |=> FRAME.status[1:0] == 2'b00)
        else $error("Error bits not zero");
    AST_STAT_REV4: assert property (FRAME_REQ && SETUP_CFG[CFG_STAT_REV4] && (sens || func)
        |=> FRAME.status[1:0] == 2'b11)
        else $error("Error bits missing");
    AST_FC_FUNC: assert property (FRAME_REQ && func && !SETUP_CFG[CFG_FC_ERR_OFF] |=> ch1 == 12'hFFA)
        else $error("No 4090 code");
    AST_FC_SENS: assert property (FRAME_REQ && sens && !func && !SETUP_CFG[CFG_FC_ERR_OFF] |=> ch1 == 12'hFFB)
        else $error("No 4091 code");
    AST_CLAMP_HI: assert property (FRAME_REQ && (SETUP_CFG[CFG_FC_ERR_OFF] || !(sens || func))
        && FAST_IN.ch1 > FAST_IN.clamp_hi |=> ch1 == $past(FAST_IN.clamp_hi))
        else $error("No high clamp");
    AST_SLOW_OFF: assert property (SETUP_CFG[CFG_SLOW_OFF] [*3] ##0 FRAME_REQ
        |=> !SLOW_ACTIVE && FRAME.status[3:2] == 2'b00)
        else $error("Slow bits while off");
    AST_MSG_DONE: assert property (MSG_DONE |-> FRAME_VALID ##1 !MSG_DONE)
        else $error("Stray message end");
    cover property (FRAME_REQ && ROLL_COUNT == 4'hF);
    cover property (MSG_DONE);
    cover property (FRAME_REQ && func && SETUP_CFG[CFG_STAT_REV4]);
endmodule
bind spcb_frame_builder spcb_frame_builder_asserts u_asserts (
    .CLK(CLK), .ARST_N(ARST_N), .SETUP_CFG(SETUP_CFG), .FAST_IN(FAST_IN), .ERROR_FLAGS(ERROR_FLAGS),
    .FRAME_REQ(FRAME_REQ), .FRAME_VALID(FRAME_VALID), .FRAME(FRAME), .ROLL_COUNT(ROLL_COUNT),
    .SLOW_ACTIVE(SLOW_ACTIVE), .MSG_DONE(MSG_DONE)
);
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Bench for the frame builder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import spcb_pkg::*;
    localparam logic [11:0] MAKER = 12'h3C3; // Arbitrary value
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic req = 1'b0;
    logic a1 = 1'b0;
    logic a0 = 1'b0;
    spcb_cfg_t cfg = 16'h0010;
    spcb_fast_t fin = '0;
    logic [11:0] err = 12'h000;
    logic [11:0] temp;
    spcb_cust_t cust;
    logic [15:0] sn1, sn2;
    logic fv, sa, md, mv;
    spcb_frame_t frm;
    logic [3:0] rcnt;
    logic [7:0] mid, rid;
    logic [11:0] rdat;
    logic [3:0] rc4 = 4'h0;
    logic [1:0] rc2 = 2'h0;
    logic [36:0] fq[$];
    logic [19:0] mq[$];
    int n_errors = 0;
    int checks_done = 0;
    always #2.5 clk = ~clk;
    spcb_frame_builder #(.MANUF_CODE(MAKER)) u_dut (
        .CLK(clk), .ARST_N(arst_n), .SETUP_CFG(cfg), .SENSOR_ADDRESS_BIT1(a1), .SENSOR_ADDRESS_BIT0(a0),
        .FAST_IN(fin), .TEMP_SLOW(temp), .ERROR_FLAGS(err), .CUSTOMER_INFO_WORDS(cust),
        .FACTORY_SERIAL_WORD1(sn1), .FACTORY_SERIAL_WORD2(sn2), .FRAME_REQ(req), .FRAME_VALID(fv),
        .FRAME(frm), .ROLL_COUNT(rcnt), .SLOW_ACTIVE(sa), .MSG_DONE(md), .MSG_ID_OUT(mid)
    );
    spcb_ecu_model u_ecu (.clk(clk), .frame_valid(fv), .frame(frm), .msg_valid(mv), .msg_id(rid), .msg_data(rdat));
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("%0d checks %0d errors", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    function automatic logic [3:0] crc4(input logic [3:0] c, n);
        for (int i = 3; i >= 0; i--) c = {c[2:0], n[i]} ^ (c[3] ? 4'hD : 4'h0);
        return c;
    endfunction
    function automatic logic [11:0] clampv(input logic [11:0] v, lo, hi);
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction
    function automatic logic [19:0] item(input int b, k);
        logic [47:0] w;
        logic [31:0] s;
        logic [7:0] ids [4] = '{8'h03, 8'h05, 8'h06, 8'h23};
        w = (b > 1) ? {cust[3 * b - 3], cust[3 * b - 4], cust[3 * b - 5]} : '0;
        s = {sn1, sn2} >> (24 - 8 * k);
        if (b == 0) return {ids[k], k == 0 ? cust[0][11:0] : k == 1 ? MAKER : k == 2 ? 12'h004 : temp};
        if (b == 1) return {8'h29 + 8'(k), 4'h0, s[7:0]};
        return {(b == 2 ? 8'h07 : b == 3 ? 8'h90 : 8'h94) + 8'(k), w[12 * k +: 12]};
    endfunction
    task automatic idle(input int n);
        req <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic send(input int gap, input logic full, input spcb_cfg_t c);
        spcb_fast_t nf;
        logic [11:0] ne, v1, v2;
        logic [3:0] k;
        logic bad;
        spcb_frame_t f;
        nf = {12'($urandom), 12'($urandom), 12'($urandom % 2048), 12'(2048 + $urandom % 2048)};
        case ($urandom % 4)
            0: ne = 12'h000;
            1: ne = 12'($urandom) & ERR_SENSOR_MASK;
            2: ne = 12'($urandom);
            default: ne = 12'h020;
        endcase
        if (!full) ne = err;
        bad = |(ne & (ERR_SENSOR_MASK | ERR_FUNC_MASK));
        v1 = clampv(nf.ch1, nf.clamp_lo, nf.clamp_hi);
        v2 = clampv(nf.ch2, nf.clamp_lo, nf.clamp_hi);
        if (bad && !c[5]) begin
            v1 = |(ne & ERR_FUNC_MASK) ? 12'hFFA : 12'hFFB;
            v2 = v1;
        end
        if (c[15]) v2[3:0] = rc4;
        f.status = {2'b00, {2{c[6] & bad}}};
        f.data = {v2[3:0], v2[7:4], v2[11:8], v1[3:0], v1[7:4], v1[11:8]};
        k = 4'h5;
        if (c[7]) k = crc4(k, {c[13] ? {a1, a0} : 2'b00, c[14] ? rc2 : 2'b00});
        if (c[11]) k = crc4(k, f.status);
        for (int i = 0; i < 6; i++) k = crc4(k, f.data[i]);
        if (!c[12]) k = crc4(k, 4'h0);
        f.crc = k;
        rc4 = (rc4 == 4'hF) ? 4'h1 : rc4 + 4'h1;
        rc2 = rc2 + 2'h1;
        fq.push_back({full, rc4, f});
        cfg <= c;
        fin <= nf;
        err <= ne;
        req <= 1'b1;
        @(posedge clk);
        if (gap > 0) idle(gap);
    endtask
    task automatic slow_run(input string name, input spcb_cfg_t c, input int nblk);
        err <= 12'($urandom);
        cfg <= c | 16'h0010;
        idle(4);
        for (int b = 0; b < nblk; b++) begin
            for (int k = 0; k < 4; k++) begin
                if (k == 0 || c[0]) mq.push_back({8'h01, (err & 12'hEFF) | 12'h800});
                mq.push_back(item(b, k));
            end
        end
        cfg <= c;
        idle(3);
        for (int i = 0; i < 1000 && mq.size() > 0; i++) send(2, 1'b0, c);
        chk("msg_left", 0, mq.size());
        if (mq.size() != 0) final_report();
        cfg <= c | 16'h0010;
        idle(4);
        $display("Test %s done", name);
    endtask
    always @(posedge clk) begin
        logic [36:0] e;
        logic [19:0] m;
        if (arst_n && fv === 1'b1) begin
            e = fq.pop_front();
            chk("roll_count", 32'(e[35:32]), 32'(rcnt));
            if (e[36]) chk("frame", e[31:0], frm);
            else chk("frame_data", e[31:0] & 32'h3FFFFFF0, frm & 32'h3FFFFFF0);
        end
        if (mv === 1'b1) begin
            m = mq.pop_front();
            chk("message", 32'(m), 32'({rid, rdat}));
        end
    end
    initial begin
        void'($urandom(7));
        cust <= {$urandom, $urandom, $urandom, $urandom, $urandom};
        sn1 <= 16'($urandom);
        sn2 <= 16'($urandom);
        temp <= 12'(1 + $urandom % 4088);
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        idle(4);
        for (int a = 0; a < 4; a++) begin
            {a1, a0} <= 2'(a);
            idle(4);
            for (int i = 0; i < 80; i++) send($urandom % 3, 1'b1, 16'($urandom) & 16'hF8E0 | 16'h0010);
            idle(3);
        end
        $display("Test fast_crc done");
        slow_run("slow_blocks", 16'h0048, 5);
        slow_run("slow_alternate", 16'h0001, 1);
        arst_n <= 1'b0;
        @(posedge clk);
        chk("roll_count_reset", 0, 32'(rcnt));
        arst_n <= 1'b1;
        {rc4, rc2} = '0;
        idle(4);
        for (int i = 0; i < 40; i++) send(1, 1'b1, 16'($urandom) & 16'hF8E0 | 16'h0010);
        idle(3);
        $display("Test reset_restart done");
        final_report();
    end
endmodule
`default_nettype wire

// ---- verilog/spcb_crc4.sv ----
// Checksum nibble over selected nibbles
`timescale 1ns/10ps
`default_nettype none
module spcb_crc4 (
    // Nibbles in feed order and their selects
    input wire logic [7:0][3:0] nib,
    input wire logic [7:0] use_nib,
    // Legacy mode drops the trailing zero nibble
    input wire logic legacy,
    // Result
    output logic [3:0] crc
);
    import spcb_pkg::*;

    function automatic logic [3:0] step(input logic [3:0] c_in, input logic [3:0] n);
        logic [3:0] c;
        logic fb;
        c = c_in;
        for (int b = 3; b >= 0; b--) begin
            fb = c[3];
            c = {c[2:0], n[b]} ^ (fb ? CRC4_POLY : 4'h0);
        end
        return c;
    endfunction

    always_comb begin
        logic [3:0] c;
        c = CRC4_SEED;
        for (int i = 0; i < 8; i++) begin
            if (use_nib[i]) begin
                c = step(c, nib[i]);
            end
        end
        if (!legacy) begin
            c = step(c, 4'h0);
        end
        crc = c;
    end
endmodule
`default_nettype wire

// ---- verilog/spcb_frame_builder.sv ----
// SPC frame content builder
// Functional notes
// [RULE_01] Error indication sits in status bits 3 and 2, not the two low bits.
// [RULE_02] Status nibble goes out with its bit order reversed.
// [RULE_03] Setup bit 6 clear: status error bits always zero.
// [RULE_04] Setup bit 6 set: both error bits one on sensor or processing error.
// [RULE_05] Fast channel errors replace both payloads with 4091 or 4090.
// [RULE_06] Fast channel values are limited to the lower and upper clamp settings.
// [RULE_07] Setup bit 5 disables error codes; data keeps flowing, status still per bit 6.
// [RULE_08] Checksum nibble uses x^4+x^3+x^2+1 with seed 0101.
// [RULE_09] Setup bit 12 selects the legacy checksum calculation.
// [RULE_10] Setup bit 11 includes the status nibble in the checksum.
// [RULE_11] Virtual nibble: address in bits 3:2, 2-bit counter in 1:0, zeros else.
// [RULE_12] Setup bits 14, 13 and 7 control the virtual nibble.
// [RULE_13] 4-bit counter starts at 0, counts to 15, then wraps to 1.
// [RULE_14] 2-bit counter starts at 0, counts to 3, wraps to 0.
// [RULE_15] Both counters advance after every frame, error frames included.
// [RULE_16] Slow channel rides the two low status bits, 8-bit ID and 12-bit data.
// [RULE_17] Setup bit 4 switches the slow channel off.
// [RULE_18] Setup bits 3:1 pick blocks; block 1 always; each block opens with error code.
// [RULE_19] Block 1: IDs 01, 03, 05, 06, 23 with type, maker, revision, temperature.
// [RULE_20] Block 3: error code, IDs 07..0A as 12-bit slices of words 1 to 3.
// [RULE_21] Block 4: error code, IDs 90..93 as 12-bit slices of words 4 to 6.
// [RULE_22] Block 2: error code, IDs 29..2C, serial bytes MSB first, right aligned.
// [RULE_23] Each message spreads bit by bit over frames with start, config and CRC bits.
// [RULE_24] Setup bit 0 sends the error-code message as every second message.
// [RULE_25] Error-code message has ID 01, one data bit per internal error type.
`timescale 1ns/10ps
`default_nettype none
module spcb_frame_builder #(
    // Arbitrary neutral maker code
    parameter logic [11:0] MANUF_CODE = spcb_pkg::MANUF_CODE_DFLT
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Setup and address straps
    input wire spcb_pkg::spcb_cfg_t SETUP_CFG,
    input wire logic SENSOR_ADDRESS_BIT1,
    input wire logic SENSOR_ADDRESS_BIT0,
    // Measurement and diagnostics
    input wire spcb_pkg::spcb_fast_t FAST_IN,
    input wire logic [11:0] TEMP_SLOW,
    input wire logic [11:0] ERROR_FLAGS,
    // Identification words
    input wire spcb_pkg::spcb_cust_t CUSTOMER_INFO_WORDS,
    input wire logic [15:0] FACTORY_SERIAL_WORD1,
    input wire logic [15:0] FACTORY_SERIAL_WORD2,
    // Frame request and result
    input wire logic FRAME_REQ,
    output logic FRAME_VALID,
    output var spcb_pkg::spcb_frame_t FRAME,
    // Status
    output logic [3:0] ROLL_COUNT,
    output logic SLOW_ACTIVE,
    output logic MSG_DONE,
    output logic [7:0] MSG_ID_OUT
);
    import spcb_pkg::*;

    logic rst_meta_ff;
    logic rst_sync_ff;
    logic [1:0] addr_meta_ff;
    logic [1:0] addr_ff;
    logic [3:0] rc4_ff;
    logic [1:0] frame_count_ff;
    spcb_sc_state_t sc_state_ff;
    spcb_sc_state_t nxt_sc_state;
    logic [2:0] blk_ff;
    logic [2:0] idx_ff;
    logic err_turn_ff;
    logic [4:0] pos_ff;
    logic [SER_LEN-1:0] sh3_ff;
    logic [SER_LEN-1:0] sh2_ff;
    logic frame_valid_ff;
    spcb_frame_t frame_ff;
    logic msg_done_ff;
    logic [7:0] msg_id_ff;

    // Reset release through two flops
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    wire logic rst_n = rst_sync_ff;

    // Straps are board pins
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            addr_meta_ff <= 2'h0;
            addr_ff <= 2'h0;
        end else begin
            addr_meta_ff <= {SENSOR_ADDRESS_BIT1, SENSOR_ADDRESS_BIT0};
            addr_ff <= addr_meta_ff;
        end
    end

    // Error classes
    logic sensor_err;
    logic func_err;
    logic any_err;
    assign sensor_err = |(ERROR_FLAGS & ERR_SENSOR_MASK);
    assign func_err = |(ERROR_FLAGS & ERR_FUNC_MASK);
    assign any_err = sensor_err | func_err;

    // Processing error outranks sensor error
    function automatic logic [11:0] fast_value(input logic [11:0] v, input logic fc_err_off,
                                               input logic s_err, input logic f_err,
                                               input logic [11:0] lo, input logic [11:0] hi);
        logic [11:0] r;
        if (!fc_err_off && f_err) begin
            r = FC_FUNC_ERR; // RULE_05
        end else if (!fc_err_off && s_err) begin
            r = FC_SENSOR_ERR; // RULE_05
        end else if (v > hi) begin
            r = hi; // RULE_06
        end else if (v < lo) begin
            r = lo; // RULE_06
        end else begin
            r = v; // RULE_07
        end
        return r;
    endfunction

    logic [11:0] ch1_val;
    logic [11:0] ch2_val;
    assign ch1_val = fast_value(FAST_IN.ch1, SETUP_CFG[CFG_FC_ERR_OFF], sensor_err, func_err,
                                FAST_IN.clamp_lo, FAST_IN.clamp_hi);
    assign ch2_val = fast_value(FAST_IN.ch2, SETUP_CFG[CFG_FC_ERR_OFF], sensor_err, func_err,
                                FAST_IN.clamp_lo, FAST_IN.clamp_hi);

    // Slow channel control
    logic slow_on;
    logic alt_mode;
    logic [2:0] last_blk;
    logic msg_end;
    assign slow_on = !SETUP_CFG[CFG_SLOW_OFF]; // RULE_17
    assign alt_mode = SETUP_CFG[CFG_ALT_ERR];
    assign last_blk = (SETUP_CFG[CFG_BLK_HI:CFG_BLK_LO] > LAST_BLK) ? LAST_BLK
                      : SETUP_CFG[CFG_BLK_HI:CFG_BLK_LO]; // RULE_18
    assign msg_end = (sc_state_ff == SC_SEND) && FRAME_REQ && (pos_ff == SER_LAST);

    always_comb begin
        nxt_sc_state = sc_state_ff;
        unique case (sc_state_ff)
            SC_OFF: begin
                if (slow_on) begin
                    nxt_sc_state = SC_LOAD;
                end
            end
            SC_LOAD: begin
                nxt_sc_state = slow_on ? SC_SEND : SC_OFF;
            end
            SC_SEND: begin
                if (!slow_on) begin
                    nxt_sc_state = SC_OFF;
                end else if (msg_end) begin
                    nxt_sc_state = SC_LOAD;
                end
            end
            default: begin
                nxt_sc_state = SC_OFF;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sc_state_ff <= SC_OFF;
        end else begin
            sc_state_ff <= nxt_sc_state;
        end
    end

    // Message selection
    logic is_err_msg;
    logic [1:0] item;
    logic [31:0] serial_words;
    logic [47:0] cust_slices;
    spcb_msg_t cur_msg;
    assign is_err_msg = (idx_ff == 3'h0) || (alt_mode && err_turn_ff); // RULE_24
    assign item = 2'(idx_ff - IDX_FIRST_ITEM);
    assign serial_words = {FACTORY_SERIAL_WORD1, FACTORY_SERIAL_WORD2};

    always_comb begin
        cust_slices = 48'h0;
        if (blk_ff > BLK_SERIAL && blk_ff <= LAST_BLK) begin
            cust_slices = {CUSTOMER_INFO_WORDS[CUST_BASE[blk_ff] + 2],
                           CUSTOMER_INFO_WORDS[CUST_BASE[blk_ff] + 1],
                           CUSTOMER_INFO_WORDS[CUST_BASE[blk_ff]]};
        end
    end

    always_comb begin
        cur_msg.id = ERR_MSG_ID; // RULE_25
        cur_msg.data = (ERROR_FLAGS & ~ERR_RSVD_MASK) | ERR_ONE_MASK; // RULE_25
        if (!is_err_msg && blk_ff <= LAST_BLK) begin
            cur_msg.id = MSG_ID[blk_ff][item];
            if (blk_ff == 3'h0) begin
                unique case (item)
                    2'h0: cur_msg.data = CUSTOMER_INFO_WORDS[0][11:0]; // RULE_19
                    2'h1: cur_msg.data = MANUF_CODE; // RULE_19
                    2'h2: cur_msg.data = PROTO_REV; // RULE_19
                    2'h3: cur_msg.data = TEMP_SLOW; // RULE_19
                endcase
            end else if (blk_ff == BLK_SERIAL) begin
                cur_msg.data = {4'h0, serial_words[31 - 8 * item -: 8]}; // RULE_22
            end else begin
                cur_msg.data = cust_slices[12 * item +: 12]; // RULE_20 RULE_21
            end
        end
    end

    // Advances once per finished message
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            blk_ff <= 3'h0;
            idx_ff <= 3'h0;
            err_turn_ff <= 1'b1;
        end else if (!slow_on) begin
            blk_ff <= 3'h0;
            idx_ff <= 3'h0;
            err_turn_ff <= 1'b1;
        end else if (msg_end) begin
            if (alt_mode && err_turn_ff) begin
                err_turn_ff <= 1'b0; // RULE_24
                if (idx_ff == 3'h0) begin
                    idx_ff <= IDX_FIRST_ITEM;
                end
            end else begin
                err_turn_ff <= 1'b1;
                if (idx_ff == IDX_LAST) begin
                    // Wrap to block 1 after the last enabled
                    idx_ff <= alt_mode ? IDX_FIRST_ITEM : 3'h0; // RULE_18
                    blk_ff <= (blk_ff >= last_blk) ? 3'h0 : 3'(blk_ff + 3'h1); // RULE_18
                end else begin
                    idx_ff <= 3'(idx_ff + 3'h1);
                end
            end
        end
    end

    // Loaded whole so the CRC6 is fixed
    logic [11:0] hdr_tail;
    assign hdr_tail = {1'b0, SER_CFG_BIT, cur_msg.id[7:4], 1'b0, cur_msg.id[3:0], 1'b0};

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sh3_ff <= '0;
            sh2_ff <= '0;
            pos_ff <= 5'h0;
            msg_id_ff <= 8'h00;
        end else if (sc_state_ff == SC_LOAD) begin
            sh3_ff <= {SER_SYNC, hdr_tail}; // RULE_23
            sh2_ff <= {crc6_msg(hdr_tail, cur_msg.data), cur_msg.data}; // RULE_23
            pos_ff <= 5'h0;
            msg_id_ff <= cur_msg.id;
        end else if (sc_state_ff == SC_SEND && FRAME_REQ) begin
            sh3_ff <= {sh3_ff[SER_LEN-2:0], 1'b0}; // RULE_16
            sh2_ff <= {sh2_ff[SER_LEN-2:0], 1'b0}; // RULE_16
            pos_ff <= 5'(pos_ff + 5'h1);
        end
    end

    // Zero serial bits unless sending
    logic ser_hi;
    logic ser_lo;
    assign ser_hi = (sc_state_ff == SC_SEND) && sh3_ff[SER_LEN-1]; // RULE_16
    assign ser_lo = (sc_state_ff == SC_SEND) && sh2_ff[SER_LEN-1]; // RULE_16

    // Status nibble, reversed on the wire
    logic [1:0] stat_err;
    logic [3:0] stat_log;
    logic [3:0] stat_tx;
    assign stat_err = (SETUP_CFG[CFG_STAT_REV4] && any_err) ? 2'h3 : 2'h0; // RULE_03 RULE_04
    assign stat_log = {stat_err, ser_hi, ser_lo}; // RULE_01
    assign stat_tx = {stat_log[0], stat_log[1], stat_log[2], stat_log[3]}; // RULE_02

    // Last data nibble may carry the counter
    logic [5:0][3:0] data_nib;
    always_comb begin
        data_nib[0] = ch1_val[11:8];
        data_nib[1] = ch1_val[7:4];
        data_nib[2] = ch1_val[3:0];
        data_nib[3] = ch2_val[11:8];
        data_nib[4] = ch2_val[7:4];
        data_nib[5] = SETUP_CFG[CFG_RC4_TX] ? rc4_ff : ch2_val[3:0];
    end

    // Checksummed, never sent
    logic [3:0] virt_nib;
    assign virt_nib = {SETUP_CFG[CFG_VN_ID] ? addr_ff : 2'h0,
                       SETUP_CFG[CFG_VN_RC] ? frame_count_ff : 2'h0}; // RULE_11 RULE_12

    logic [3:0] crc_nib;
    spcb_crc4 u_crc (
        .nib({data_nib, stat_tx, virt_nib}),
        .use_nib({6'h3F, SETUP_CFG[CFG_CRC_STAT], SETUP_CFG[CFG_VN_EN]}), // RULE_10 RULE_12
        .legacy(SETUP_CFG[CFG_CRC_LEGACY]), // RULE_09
        .crc(crc_nib) // RULE_08
    );

    // Step on every frame, errors or not
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rc4_ff <= RC4_RESET; // RULE_13
        end else if (FRAME_REQ) begin
            rc4_ff <= (rc4_ff == RC4_MAX) ? RC4_WRAP : 4'(rc4_ff + 4'h1); // RULE_13 RULE_15
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            frame_count_ff <= RC2_RESET; // RULE_14
        end else if (FRAME_REQ) begin
            frame_count_ff <= (frame_count_ff == RC2_MAX) ? RC2_RESET
                              : 2'(frame_count_ff + 2'h1); // RULE_14 RULE_15
        end
    end

    // Captured with pre-step counters
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            frame_valid_ff <= 1'b0;
            frame_ff <= '0;
        end else begin
            frame_valid_ff <= FRAME_REQ;
            if (FRAME_REQ) begin
                frame_ff.status <= stat_tx;
                frame_ff.data <= data_nib;
                frame_ff.crc <= crc_nib;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            msg_done_ff <= 1'b0;
        end else begin
            msg_done_ff <= msg_end;
        end
    end

    assign FRAME_VALID = frame_valid_ff;
    assign FRAME = frame_ff;
    assign ROLL_COUNT = rc4_ff;
    assign SLOW_ACTIVE = sc_state_ff[1];
    assign MSG_DONE = msg_done_ff;
    assign MSG_ID_OUT = msg_id_ff;
endmodule
`default_nettype wire
